// File: logic/ufc_consts.vh
`ifndef UFC_CONSTS_VH
`define UFC_CONSTS_VH

`define UFC_CTRL_ADDR    8'hC2
`define UFC_CTRL_RESET   8'h01
`define UFC_EN_RESET     1'b1
`define UFC_RDATA_RESET  8'h00
`define UFC_BIT_EN       0
`define UFC_BIT_TXCLR    1
`define UFC_BIT_RXCLR    2
`define UFC_THR_HI       7
`define UFC_THR_LO       6
`define UFC_THR_RESET    2'h0
`define UFC_THR_CODE1    2'h0
`define UFC_THR_CODE4    2'h1
`define UFC_THR_CODE8    2'h2
`define UFC_THR_CODE14   2'h3
`define UFC_THR_N1       8'h01
`define UFC_THR_N4       8'h04
`define UFC_THR_N8       8'h08
`define UFC_THR_N14      8'h0E
`define UFC_DEPTH        16
`define UFC_ERR_W        3

`endif

// File: logic/ufc_buf.v
`timescale 1ns/1ns
`default_nettype none
module ufc_buf #(
  parameter W     = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire          core_clk,   // system clock
  input  wire          rstn,       // async reset, active low
  input  wire          flush,      // empty buffer, reset pointers
  input  wire          single,     // hold one entry only
  input  wire          in_valid,   // writer offers an entry
  input  wire [W-1:0]  in_data,    // entry from writer
  output wire          in_ready,   // room for an entry
  output wire          out_valid,  // entry available
  output wire [W-1:0]  out_data,   // oldest entry
  input  wire          out_ready,  // reader takes oldest entry
  output wire [AW:0]   level       // entries held
);
  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0]   cnt_r;
  wire [AW:0]  cap;
  wire         push;
  wire         pop;

  assign cap       = single ? {{AW{1'b0}}, 1'b1} : DEPTH[AW:0];
  assign in_ready  = (cnt_r < cap) && !flush;
  assign out_valid = (cnt_r != {(AW+1){1'b0}}) && !flush;
  assign out_data  = mem[rd_ptr_r];
  assign level     = cnt_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      cnt_r    <= {(AW+1){1'b0}};
    end else if (flush) begin
      // flush drops data and any flags stored with it
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      cnt_r    <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // ufc_buf
`default_nettype wire

// File: logic/ufc_fifo_ctrl.v
`timescale 1ns/1ns
`default_nettype none
`include "ufc_consts.vh"
module ufc_fifo_ctrl #(
  parameter [7:0] CTRL_ADDR = `UFC_CTRL_ADDR,
  parameter       DEPTH     = `UFC_DEPTH,
  parameter       AW        = 4
) (
  input  wire                    core_clk,            // system clock, 100 MHz
  input  wire                    rstn,                // async reset, active low
  input  wire [7:0]              io_addr,             // i/o address
  input  wire                    io_wr,               // i/o write strobe
  input  wire                    io_rd,               // i/o read strobe
  input  wire [7:0]              io_wdata,            // i/o write data
  output reg  [7:0]              io_rdata,            // read data, one cycle after strobe
  output reg                     io_rvalid,           // read data valid pulse
  input  wire [7:0]              interrupt_ident_reg, // value returned on reads
  input  wire                    tx_in_valid,         // cpu offers tx byte
  input  wire [7:0]              tx_in_data,          // tx byte
  output wire                    tx_in_ready,         // tx buffer has room
  output wire                    tx_out_valid,        // byte ready for serialiser
  output wire [7:0]              tx_out_data,         // byte for serialiser
  input  wire                    tx_out_ready,        // serialiser takes byte
  input  wire                    rx_in_valid,         // deserialiser offers byte
  input  wire [7:0]              rx_in_data,          // received byte
  input  wire [`UFC_ERR_W-1:0]   rx_in_err,           // per-byte error flags
  output wire                    rx_in_ready,         // rx buffer has room
  output wire                    rx_out_valid,        // received byte available
  output wire [7:0]              rx_out_data,         // oldest received byte
  output wire [`UFC_ERR_W-1:0]   rx_out_err,          // its error flags
  input  wire                    rx_out_ready,        // cpu takes received byte
  output wire                    buffering_on,        // buffers enabled, from register
  output wire [1:0]              rx_threshold_select, // threshold code, from register
  output reg                     tx_buffer_flush,     // tx flush pulse
  output reg                     rx_buffer_flush,     // rx flush pulse
  output reg                     rx_data_irq,         // receive data interrupt level
  output wire [AW:0]             rx_level,            // bytes in rx buffer
  output wire [AW:0]             tx_level             // bytes in tx buffer
);
  reg  [1:0]  thr_r;
  reg  [1:0]  thr_nxt;
  reg         en_r;
  reg         en_nxt;
  reg         txf_nxt;
  reg         rxf_nxt;
  reg         irq_nxt;
  wire        wr_hit;
  wire        rd_hit;
  wire        new_en;
  wire        mode_flip;
  wire [AW:0] thr_cnt;

  // one decode for both strobes so reads and writes never disagree on the address
  function addr_hit;
    input       strobe;
    input [7:0] addr;
    begin
      addr_hit = strobe && (addr == CTRL_ADDR);
    end
  endfunction

  // disabled, the path is a one-byte holding register, so any byte raises the line
  function [AW:0] thr_count;
    input [1:0] sel;
    input       on;
    reg   [7:0] num;
    begin
      if (!on) begin
        num = `UFC_THR_N1;
      end else begin
        case (sel)
          `UFC_THR_CODE1:  num = `UFC_THR_N1;
          `UFC_THR_CODE4:  num = `UFC_THR_N4;
          `UFC_THR_CODE8:  num = `UFC_THR_N8;
          `UFC_THR_CODE14: num = `UFC_THR_N14;
          default:         num = `UFC_THR_N1;
        endcase
      end
      thr_count = num[AW:0];
    end
  endfunction

  assign wr_hit    = addr_hit(io_wr, io_addr);
  assign rd_hit    = addr_hit(io_rd, io_addr);
  assign new_en    = io_wdata[`UFC_BIT_EN];
  assign mode_flip = wr_hit && (new_en != en_r);

  // write-only register: bits 5:3 are expected zero and simply not stored
  always @* begin
    en_nxt  = en_r;
    thr_nxt = thr_r;
    if (wr_hit) begin
      en_nxt = new_en;
      if (new_en) begin
        thr_nxt = io_wdata[`UFC_THR_HI:`UFC_THR_LO];
      end
    end
  end

  // a mode change restarts both paths so no stale depth survives
  always @* begin
    txf_nxt = mode_flip;
    rxf_nxt = mode_flip;
    if (wr_hit && new_en) begin
      txf_nxt = mode_flip | io_wdata[`UFC_BIT_TXCLR];
      rxf_nxt = mode_flip | io_wdata[`UFC_BIT_RXCLR];
    end
  end

  // out of reset both buffers are on
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      en_r <= `UFC_EN_RESET;
    end else begin
      en_r <= en_nxt;
    end
  end

  // kept while disabled; the irq compares against one byte then
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      thr_r <= `UFC_THR_RESET;
    end else begin
      thr_r <= thr_nxt;
    end
  end

  // flush pulses last one cycle; the buffers clear on the edge that ends them
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_buffer_flush <= 1'b0;
    end else begin
      tx_buffer_flush <= txf_nxt;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_buffer_flush <= 1'b0;
    end else begin
      rx_buffer_flush <= rxf_nxt;
    end
  end

  // one pulse per hit, so back-to-back reads each get their own
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= rd_hit;
    end
  end

  // reads at the shared address see the ident value, never this register
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      io_rdata <= `UFC_RDATA_RESET;
    end else if (rd_hit) begin
      io_rdata <= interrupt_ident_reg;
    end
  end

  assign buffering_on        = en_r;
  assign rx_threshold_select = thr_r;
  assign thr_cnt             = thr_count(thr_r, en_r);

  // both paths share one buffer module; only the entry width differs
  ufc_buf #(
    .W     (8),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_tx (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .flush     (tx_buffer_flush),
    .single    (!en_r),
    .in_valid  (tx_in_valid),
    .in_data   (tx_in_data),
    .in_ready  (tx_in_ready),
    .out_valid (tx_out_valid),
    .out_data  (tx_out_data),
    .out_ready (tx_out_ready),
    .level     (tx_level)
  );

  // error flags travel in the same entry so a flush discards them too
  ufc_buf #(
    .W     (8 + `UFC_ERR_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_rx (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .flush     (rx_buffer_flush),
    .single    (!en_r),
    .in_valid  (rx_in_valid),
    .in_data   ({rx_in_err, rx_in_data}),
    .in_ready  (rx_in_ready),
    .out_valid (rx_out_valid),
    .out_data  ({rx_out_err, rx_out_data}),
    .out_ready (rx_out_ready),
    .level     (rx_level)
  );

  // the flush cycle still shows the old level, so the line is held low then
  always @* begin
    irq_nxt = 1'b0;
    if (!rx_buffer_flush) begin
      irq_nxt = (rx_level >= thr_cnt);
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_data_irq <= 1'b0;
    end else begin
      rx_data_irq <= irq_nxt;
    end
  end
endmodule // ufc_fifo_ctrl
`default_nettype wire

// File: testbench/ufc_fifo_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module ufc_asserts #(
  parameter [7:0] CTRL_ADDR = 8'hC2,
  parameter       AW        = 4
) (
  input wire logic        core_clk,            // clock
  input wire logic        rstn,                // reset
  input wire logic [7:0]  io_addr,             // address
  input wire logic        io_wr,               // write strobe
  input wire logic        io_rd,               // read strobe
  input wire logic [7:0]  io_wdata,            // write data
  input wire logic [7:0]  io_rdata,            // read data
  input wire logic        io_rvalid,           // read valid
  input wire logic [7:0]  interrupt_ident_reg, // ident value
  input wire logic        buffering_on,        // enable bit
  input wire logic [1:0]  rx_threshold_select, // threshold code
  input wire logic        tx_buffer_flush,     // tx flush
  input wire logic        rx_buffer_flush,     // rx flush
  input wire logic [AW:0] rx_level,            // rx fill
  input wire logic [AW:0] tx_level             // tx fill
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire hw = io_wr && io_addr == CTRL_ADDR;
  wire hr = io_rd && io_addr == CTRL_ADDR;
  a_read_answer: assert property (hr |=> io_rvalid && io_rdata == $past(interrupt_ident_reg))
    else $error("read answer wrong");
  a_read_miss: assert property (!hr |=> !io_rvalid)
    else $error("stray read valid");
  a_enable_write: assert property (hw |=> buffering_on == $past(io_wdata[0]))
    else $error("enable bit not stored");
  a_thr_write: assert property (hw && io_wdata[0] |=> rx_threshold_select == $past(io_wdata[7:6]))
    else $error("threshold not stored");
  a_tx_clear: assert property (hw && io_wdata[0] && io_wdata[1] |=> tx_buffer_flush ##1 tx_level == 0)
    else $error("tx clear missed");
  a_rx_clear: assert property (hw && io_wdata[0] && io_wdata[2] |=> rx_buffer_flush ##1 rx_level == 0)
    else $error("rx clear missed");
  a_clear_ignored: assert property (hw && !io_wdata[0] && !buffering_on |=> !tx_buffer_flush && !rx_buffer_flush)
    else $error("clear while disabled");
  a_reg_hold: assert property (!hw |=> $stable(buffering_on) && $stable(rx_threshold_select))
    else $error("register changed without write");
  a_single_byte: assert property (!buffering_on && !$past(buffering_on, 2) |-> rx_level <= 1 && tx_level <= 1)
    else $error("more than one byte while disabled");
  cover property (hw && io_wdata[0] && io_wdata[2]);
  cover property (io_rvalid);
  cover property (!buffering_on && rx_level == 1);
endmodule // ufc_asserts
bind ufc_fifo_ctrl ufc_asserts #(.CTRL_ADDR(CTRL_ADDR), .AW(AW)) u_chk (.core_clk(core_clk), .rstn(rstn),
  .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .io_rvalid(io_rvalid), .interrupt_ident_reg(interrupt_ident_reg), .buffering_on(buffering_on),
  .rx_threshold_select(rx_threshold_select), .tx_buffer_flush(tx_buffer_flush),
  .rx_buffer_flush(rx_buffer_flush), .rx_level(rx_level), .tx_level(tx_level));
`default_nettype wire

// File: testbench/ufc_fifo_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ufc_fifo_ctrl_tb;
  logic       core_clk, rstn, io_wr, io_rd, tx_in_valid, tx_out_ready, rx_in_valid, rx_out_ready;
  logic [7:0] io_addr, io_wdata, ident, d;
  logic [2:0] rx_in_err;
  wire  [7:0] io_rdata, rxd, txo;
  wire  [2:0] rx_out_err;
  wire  [4:0] rx_level, tx_level;
  wire  [1:0] thr;
  wire        io_rvalid, txr, txv, rxr, rxv, ben, txf, rxf, irq;
  int         failures, comparisons;
  ufc_fifo_ctrl u_dut (.core_clk(core_clk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .interrupt_ident_reg(ident),
    .tx_in_valid(tx_in_valid), .tx_in_data(d), .tx_in_ready(txr), .tx_out_valid(txv), .tx_out_data(txo),
    .tx_out_ready(tx_out_ready), .rx_in_valid(rx_in_valid), .rx_in_data(d), .rx_in_err(rx_in_err),
    .rx_in_ready(rxr), .rx_out_valid(rxv), .rx_out_data(rxd), .rx_out_err(rx_out_err),
    .rx_out_ready(rx_out_ready), .buffering_on(ben), .rx_threshold_select(thr), .tx_buffer_flush(txf),
    .rx_buffer_flush(rxf), .rx_data_irq(irq), .rx_level(rx_level), .tx_level(tx_level));
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // inputs always move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] v);
    io_addr = 8'hC2;
    io_wdata = v;
    io_wr = 1;
    cyc(1);
    io_wr = 0;
  endtask
  task automatic push_rx(input logic [2:0] e, input logic [7:0] v, input int n);
    rx_in_valid = 1;
    rx_in_err = e;
    d = v;
    cyc(n);
    rx_in_valid = 0;
  endtask
  task automatic t_read;
    ident = 8'hA5;
    io_addr = 8'hC2;
    io_rd = 1;
    cyc(1);
    chk(io_rvalid, 1);
    chk(io_rdata, 8'hA5);
    io_addr = 8'hD2;
    ident = 8'h3C;
    cyc(1);
    io_rd = 0;
    io_wr = 1;
    chk(io_rvalid, 0);
    chk(io_rdata, 8'hA5);
    cyc(1);
    io_wr = 0;
    chk(ben, 1);
    cyc(1);
  endtask
  task automatic t_thr;
    logic [7:0] n [4] = '{8'h01, 8'h04, 8'h08, 8'h0E};
    for (int c = 0; c < 4; c++) begin
      wr({c[1:0], 6'h05});
      cyc(1);
      chk(thr, c[7:0]);
      chk(rx_level, 0);
      for (int k = 1; k <= 14; k++) begin
        push_rx(3'h0, 8'h00, 1);
        cyc(1);
        chk(irq, k >= n[c]);
      end
    end
  endtask
  task automatic t_off;
    wr(8'h00);
    chk(ben, 0);
    chk(thr, 3);
    chk({txf, rxf}, 2'h3);
    cyc(1);
    push_rx(3'h0, 8'h3C, 2);
    chk(rx_level, 1);
    chk(rxr, 0);
    chk(rxd, 8'h3C);
    tx_in_valid = 1;
    cyc(2);
    tx_in_valid = 0;
    chk(tx_level, 1);
    chk(txr, 0);
    wr(8'h06);
    chk({txf, rxf}, 2'h0);
    cyc(1);
    chk(rx_level, 1);
    chk(irq, 1);
    rx_out_ready = 1;
    cyc(1);
    rx_out_ready = 0;
    chk(rx_level, 0);
    wr(8'h01);
    cyc(1);
  endtask
  task automatic t_clr;
    tx_in_valid = 1;
    for (int i = 0; i < 3; i++) begin
      d = 8'h50 + i[7:0];
      cyc(1);
    end
    tx_in_valid = 0;
    push_rx(3'h7, 8'h96, 1);
    chk(tx_level, 3);
    chk(txv, 1);
    chk(txo, 8'h50);
    chk(rx_out_err, 7);
    chk(rxd, 8'h96);
    tx_out_ready = 1;
    cyc(1);
    tx_out_ready = 0;
    chk(tx_level, 2);
    chk(txo, 8'h51);
    wr(8'h03);
    chk({txf, rxf}, 2'h2);
    cyc(1);
    chk(tx_level, 0);
    chk(rx_level, 1);
    wr(8'h05);
    cyc(1);
    chk(rxv, 0);
  endtask
  task automatic give_verdict;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    {rstn, io_wr, io_rd, tx_in_valid, tx_out_ready, rx_in_valid, rx_out_ready} = 0;
    {io_addr, io_wdata, ident, d, rx_in_err} = 0;
    repeat (4) @(posedge core_clk);
    #1 rstn = 1;
    chk(ben, 1);
    chk(thr, 0);
    t_read();
    t_thr();
    t_off();
    t_clr();
    give_verdict();
  end
  // whole run needs roughly 150 cycles
  initial begin
    #20000;
    failures++;
    give_verdict();
  end
endmodule // ufc_fifo_ctrl_tb
`default_nettype wire
